// ===== common/csm_pkg.sv
// Purpose: Constants shared by the CAN signal mapper.
// Assumes: 50 MHz system clock.
// Notes:   Register offsets are byte addresses on the Avalon-MM slave.
package csm_pkg;
  localparam int          CSM_NSIG        = 10;
  localparam int          CSM_ENTRY_BYTES = 7;
  localparam int          CSM_NATURAL     = 32;
  localparam int          CSM_FIELD_BITS  = 64;
  localparam int          CSM_MISS_LIMIT  = 2;
  localparam int          CSM_CLK_HZ      = 50_000_000;
  localparam int          CSM_TICK_MS     = 1;
  localparam int          CSM_CYC_PER_MS  = CSM_CLK_HZ / 1000 * CSM_TICK_MS;

  localparam logic [7:0]  CSM_REG_CTRL    = 8'h00;
  localparam logic [7:0]  CSM_REG_STATUS  = 8'h04;
  localparam logic [7:0]  CSM_REG_MASK    = 8'h08;
  localparam logic [7:0]  CSM_REG_CFG     = 8'h0c;
  localparam logic [7:0]  CSM_REG_RATE    = 8'h10;
  localparam logic [7:0]  CSM_REG_TMO     = 8'h14;
  localparam logic [7:0]  CSM_REG_STATE   = 8'h18;

  localparam int          CSM_ST_TIMEOUT  = 0;
  localparam int          CSM_ST_PLAUS    = 1;
  localparam int          CSM_ST_CFG_DONE = 2;
  localparam int          CSM_ST_CFG_ERR  = 3;
  localparam int          CSM_ST_DROP     = 4;
  localparam int          CSM_ST_BITS     = 5;

  localparam logic [7:0]  CSM_TYPE_PARAM  = 8'h00;
  localparam logic [7:0]  CSM_TYPE_SPEC   = 8'h02;
  localparam int          CSM_ATTR_INV    = 0;
  localparam int          CSM_ATTR_SAT    = 2;

  localparam logic [2:0]  CSM_E_TYPE      = 3'h0;
  localparam logic [2:0]  CSM_E_IDX_LO    = 3'h2;
  localparam logic [2:0]  CSM_E_IDX_HI    = 3'h3;
  localparam logic [2:0]  CSM_E_WIDTH     = 3'h4;
  localparam logic [2:0]  CSM_E_SHIFT     = 3'h5;
  localparam logic [2:0]  CSM_E_ATTR      = 3'h6;

  localparam logic        CSM_CTRL_RST    = 1'b0;
  localparam logic [4:0]  CSM_MASK_RST    = 5'h00;
  localparam logic [15:0] CSM_TMO_RST     = 16'h0000;
  localparam logic [15:0] CSM_RATE_RST    = 16'h0000;

  typedef enum logic [2:0] {
    CSM_P_TXCNT  = 3'b000,
    CSM_P_ENTRY  = 3'b001,
    CSM_P_RXCNT  = 3'b011,
    CSM_P_RATE_L = 3'b010,
    CSM_P_RATE_H = 3'b110,
    CSM_P_END    = 3'b111
  } csm_parse_e;

  typedef enum logic [1:0] {
    CSM_M_IDLE  = 2'b00,
    CSM_M_TX    = 2'b01,
    CSM_M_RXCHK = 2'b11,
    CSM_M_RXWR  = 2'b10
  } csm_mode_e;
endpackage

// ===== rtl/csm_can_signal_mapper.sv
// Purpose: Packs send signals into and unpacks receive signals from a 64-bit CAN data field.
// Assumes: All inputs synchronous to ref_clk_i; one send and one receive message layout.
// Notes:   Configuration list arrives byte by byte through the CFG register.
`timescale 1ns/1ps
module csm_can_signal_mapper
  import csm_pkg::*;
#(
  parameter int CYC_PER_MS = CSM_CYC_PER_MS,
  parameter int NSIG       = CSM_NSIG
) (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        reset_n_i,
  // Avalon-MM slave
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic             irq_o,
  // Send path
  input  wire logic        tx_start_i,
  output logic             src_param_sel_o,
  output logic             src_special_sel_o,
  output logic      [15:0] src_index_o,
  input  wire logic [31:0] src_value_i,
  output logic      [63:0] tx_data_o,
  output logic             tx_valid_o,
  // Receive path
  input  wire logic        rx_valid_i,
  input  wire logic [63:0] rx_data_i,
  output logic             snk_we_o,
  output logic             snk_param_sel_o,
  output logic             snk_special_sel_o,
  output logic      [15:0] snk_index_o,
  output logic      [31:0] snk_value_o,
  // Bus settings
  output logic      [15:0] bitrate_kbaud_o,
  output logic             cfg_valid_o
);
  localparam int SLOTS = 2 * NSIG;

  function automatic logic [63:0] fmask(input logic [7:0] w);
    logic [7:0] c;
    c = (w > 8'(CSM_NATURAL)) ? 8'(CSM_NATURAL) : w;
    fmask = (64'h1 << c) - 64'h1;
  endfunction

  function automatic logic [63:0] fit(input logic [31:0] v, input logic [7:0] w, input logic sat);
    logic [63:0] m;
    m = fmask(w);
    if (sat && (({32'h0, v} & ~m) != 64'h0)) fit = m;
    else fit = {32'h0, v} & m;
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    be_merge = (old & ~m) | (wd & m);
  endfunction

  // Avalon slave: one wait cycle, then answer
  logic                   ack;
  logic                   next_ack;
  logic [31:0]            next_readdata;
  logic                   enable;
  logic                   next_enable;
  logic [4:0]             irq_mask;
  logic [4:0]             next_irq_mask;
  logic [4:0]             status;
  logic [4:0]             next_status;
  logic [15:0]            tmo_ms;
  logic [15:0]            next_tmo_ms;
  logic                   wr_go;
  logic                   cfg_we;
  logic [4:0]             ev;
  logic [31:0]            tmp;

  // Configuration tables, send slots first then receive slots
  csm_parse_e             pstate;
  csm_parse_e             next_pstate;
  logic [7:0]             s_type [SLOTS];
  logic [15:0]            s_idx  [SLOTS];
  logic [7:0]             s_wid  [SLOTS];
  logic [7:0]             s_sft  [SLOTS];
  logic [7:0]             s_att  [SLOTS];
  logic [7:0]             n_type [SLOTS];
  logic [15:0]            n_idx  [SLOTS];
  logic [7:0]             n_wid  [SLOTS];
  logic [7:0]             n_sft  [SLOTS];
  logic [7:0]             n_att  [SLOTS];
  logic [7:0]             ntx, nrx, next_ntx, next_nrx;
  logic [3:0]             pidx, next_pidx;
  logic [2:0]             pbyte, next_pbyte;
  logic                   pdir, next_pdir;
  logic [15:0]            rate_new, next_rate_new;
  logic [15:0]            next_rate;
  logic                   next_cfg_ok;
  logic [4:0]             slot;
  logic [7:0]             cfg_b;
  logic [9:0]             tot_tx, tot_rx;
  logic [3:0]             inv_cnt;

  // Mapping engine
  csm_mode_e              mode, next_mode;
  logic [3:0]             midx, next_midx;
  logic [63:0]            frame, next_frame;
  logic [63:0]            rxbuf, next_rxbuf;
  logic                   bad, next_bad;
  logic [1:0]             miss, next_miss;
  logic [63:0]            next_tx_data;
  logic                   next_tx_valid;
  logic                   next_snk_we, next_snk_psel, next_snk_ssel;
  logic [15:0]            next_snk_index;
  logic [31:0]            next_snk_value;
  logic [4:0]             mslot;
  logic [63:0]            fld, inv, m, f_new;
  logic [8:0]             inv_pos;
  logic                   last;
  logic                   ev_tmo, ev_plaus, ev_done, ev_err, ev_drop, ev_rx_ok;

  // Receive timeout
  logic [$clog2(CYC_PER_MS)-1:0] tick_cnt, next_tick_cnt;
  logic [15:0]            ms_cnt, next_ms_cnt;
  logic                   tmo_hit, next_tmo_hit;

  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack;
  assign wr_go             = avs_write_i & ack;
  assign cfg_we            = wr_go && avs_address_i == CSM_REG_CFG && avs_byteenable_i[0];
  assign cfg_b             = avs_writedata_i[7:0];
  assign irq_o             = |(status & irq_mask);

  always_comb begin
    ev                    = 5'h00;
    ev[CSM_ST_TIMEOUT]    = ev_tmo;
    ev[CSM_ST_PLAUS]      = ev_plaus;
    ev[CSM_ST_CFG_DONE]   = ev_done;
    ev[CSM_ST_CFG_ERR]    = ev_err;
    ev[CSM_ST_DROP]       = ev_drop;
    next_ack              = (avs_read_i | avs_write_i) & ~ack;
    next_readdata         = avs_readdata_o;
    next_enable           = enable;
    next_irq_mask         = irq_mask;
    next_tmo_ms           = tmo_ms;
    next_status           = status;
    tmp                   = 32'h0;
    if (wr_go) begin
      unique case (avs_address_i)
        CSM_REG_CTRL: begin
          tmp         = be_merge({31'h0, enable}, avs_writedata_i, avs_byteenable_i);
          next_enable = tmp[0];
        end
        CSM_REG_MASK: begin
          tmp           = be_merge({27'h0, irq_mask}, avs_writedata_i, avs_byteenable_i);
          next_irq_mask = tmp[4:0];
        end
        CSM_REG_TMO: begin
          tmp         = be_merge({16'h0, tmo_ms}, avs_writedata_i, avs_byteenable_i);
          next_tmo_ms = tmp[15:0];
        end
        CSM_REG_STATUS: begin
          if (avs_byteenable_i[0]) next_status = status & ~avs_writedata_i[4:0];
        end
        default: ;
      endcase
    end
    // Hardware set beats a clear in the same cycle
    next_status = next_status | ev;
    if (avs_read_i && !ack) begin
      unique case (avs_address_i)
        CSM_REG_CTRL:   next_readdata = {31'h0, enable};
        CSM_REG_STATUS: next_readdata = {27'h0, status};
        CSM_REG_MASK:   next_readdata = {27'h0, irq_mask};
        CSM_REG_CFG:    next_readdata = {29'h0, pstate};
        CSM_REG_RATE:   next_readdata = {16'h0, bitrate_kbaud_o};
        CSM_REG_TMO:    next_readdata = {16'h0, tmo_ms};
        CSM_REG_STATE:  next_readdata = {nrx, ntx, 11'h0, miss, mode, cfg_valid_o};
        default:        next_readdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      ack            <= 1'b0;
      avs_readdata_o <= 32'h0;
      enable         <= CSM_CTRL_RST;
      irq_mask       <= CSM_MASK_RST;
      tmo_ms         <= CSM_TMO_RST;
      status         <= '0;
    end else begin
      ack            <= next_ack;
      avs_readdata_o <= next_readdata;
      enable         <= next_enable;
      irq_mask       <= next_irq_mask;
      tmo_ms         <= next_tmo_ms;
      status         <= next_status;
    end
  end

  // Configuration list parser
  always_comb begin
    next_pstate   = pstate;
    next_pidx     = pidx;
    next_pbyte    = pbyte;
    next_pdir     = pdir;
    next_ntx      = ntx;
    next_nrx      = nrx;
    next_rate_new = rate_new;
    next_rate     = bitrate_kbaud_o;
    next_cfg_ok   = cfg_valid_o;
    ev_done       = 1'b0;
    ev_err        = 1'b0;
    n_type        = s_type;
    n_idx         = s_idx;
    n_wid         = s_wid;
    n_sft         = s_sft;
    n_att         = s_att;
    slot          = pdir ? 5'(NSIG) + 5'(pidx) : 5'(pidx);
    tot_tx        = 10'h0;
    tot_rx        = 10'h0;
    inv_cnt       = 4'h0;
    for (int i = 0; i < NSIG; i++) begin
      if (8'(i) < ntx) tot_tx = tot_tx + 10'(s_wid[i]);
      if (8'(i) < nrx) begin
        tot_rx  = tot_rx + (s_att[NSIG+i][CSM_ATTR_INV] ? 10'({s_wid[NSIG+i], 1'b0}) : 10'(s_wid[NSIG+i]));
        inv_cnt = inv_cnt + 4'(s_att[NSIG+i][CSM_ATTR_INV]);
      end
    end
    if (cfg_we) begin
      unique case (pstate)
        CSM_P_TXCNT, CSM_P_RXCNT: begin
          next_pidx  = 4'h0;
          next_pbyte = 3'h0;
          next_pdir  = (pstate == CSM_P_RXCNT);
          if (cfg_b > 8'(NSIG)) begin
            ev_err      = 1'b1;
            next_pstate = CSM_P_TXCNT;
          end else if (pstate == CSM_P_TXCNT) begin
            next_cfg_ok = 1'b0;
            next_ntx    = cfg_b;
            next_pstate = (cfg_b == 8'h0) ? CSM_P_RXCNT : CSM_P_ENTRY;
          end else begin
            next_nrx    = cfg_b;
            next_pstate = (cfg_b == 8'h0) ? CSM_P_RATE_L : CSM_P_ENTRY;
          end
        end
        CSM_P_ENTRY: begin
          unique case (pbyte)
            CSM_E_TYPE:   n_type[slot]      = cfg_b;
            CSM_E_IDX_LO: n_idx[slot][7:0]  = cfg_b;
            CSM_E_IDX_HI: n_idx[slot][15:8] = cfg_b;
            CSM_E_WIDTH:  n_wid[slot]       = cfg_b;
            CSM_E_SHIFT:  n_sft[slot]       = cfg_b;
            CSM_E_ATTR:   n_att[slot]       = cfg_b;
            default: ;
          endcase
          next_pbyte = pbyte + 3'h1;
          if (pbyte == 3'(CSM_ENTRY_BYTES - 1)) begin
            next_pbyte = 3'h0;
            next_pidx  = pidx + 4'h1;
            if (8'(pidx) + 8'h1 == (pdir ? nrx : ntx))
              next_pstate = pdir ? CSM_P_RATE_L : CSM_P_RXCNT;
          end
        end
        CSM_P_RATE_L: begin
          next_rate_new[7:0] = cfg_b;
          next_pstate        = CSM_P_RATE_H;
        end
        CSM_P_RATE_H: begin
          next_rate_new[15:8] = cfg_b;
          next_pstate         = CSM_P_END;
        end
        CSM_P_END: begin
          next_pstate = CSM_P_TXCNT;
          // Layout only becomes live after a clean terminator and a legal length
          if (cfg_b == 8'h0 && tot_tx <= 10'(CSM_FIELD_BITS) && tot_rx <= 10'(CSM_FIELD_BITS)
              && (ntx == 8'h0 || tot_tx != 10'h0) && (nrx == 8'h0 || tot_rx != 10'h0)
              && inv_cnt <= 4'h1) begin
            next_cfg_ok = 1'b1;
            next_rate   = rate_new;
            ev_done     = 1'b1;
          end else begin
            ev_err = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      pstate          <= CSM_P_TXCNT;
      pidx            <= 4'h0;
      pbyte           <= 3'h0;
      pdir            <= 1'b0;
      ntx             <= 8'h0;
      nrx             <= 8'h0;
      rate_new        <= CSM_RATE_RST;
      bitrate_kbaud_o <= CSM_RATE_RST;
      cfg_valid_o     <= 1'b0;
      s_type          <= '{default: 8'h0};
      s_idx           <= '{default: 16'h0};
      s_wid           <= '{default: 8'h0};
      s_sft           <= '{default: 8'h0};
      s_att           <= '{default: 8'h0};
    end else begin
      pstate          <= next_pstate;
      pidx            <= next_pidx;
      pbyte           <= next_pbyte;
      pdir            <= next_pdir;
      ntx             <= next_ntx;
      nrx             <= next_nrx;
      rate_new        <= next_rate_new;
      bitrate_kbaud_o <= next_rate;
      cfg_valid_o     <= next_cfg_ok;
      s_type          <= n_type;
      s_idx           <= n_idx;
      s_wid           <= n_wid;
      s_sft           <= n_sft;
      s_att           <= n_att;
    end
  end

  // Source selection for the signal being packed
  assign src_param_sel_o   = mode == CSM_M_TX && s_type[midx] == CSM_TYPE_PARAM;
  assign src_special_sel_o = mode == CSM_M_TX && s_type[midx] == CSM_TYPE_SPEC;
  assign src_index_o       = s_idx[midx];

  // Mapping engine: one signal per cycle
  always_comb begin
    next_mode      = mode;
    next_midx      = midx;
    next_frame     = frame;
    next_rxbuf     = rxbuf;
    next_bad       = bad;
    next_miss      = miss;
    next_tx_data   = tx_data_o;
    next_tx_valid  = 1'b0;
    next_snk_we    = 1'b0;
    next_snk_psel  = snk_param_sel_o;
    next_snk_ssel  = snk_special_sel_o;
    next_snk_index = snk_index_o;
    next_snk_value = snk_value_o;
    ev_drop        = 1'b0;
    ev_plaus       = 1'b0;
    ev_rx_ok       = 1'b0;
    mslot          = (mode == CSM_M_TX) ? 5'(midx) : 5'(NSIG) + 5'(midx);
    m              = fmask(s_wid[mslot]);
    // Bit 0 of the field is the LSB of the first data byte
    fld            = (rxbuf >> s_sft[mslot]) & m;
    inv_pos        = {1'b0, s_sft[mslot]} + {1'b0, s_wid[mslot]};
    inv            = (rxbuf >> inv_pos) & m;
    f_new          = frame | (fit(src_value_i, s_wid[mslot], s_att[mslot][CSM_ATTR_SAT]) << s_sft[mslot]);
    last           = (mode == CSM_M_TX) ? (8'(midx) + 8'h1 >= ntx) : (8'(midx) + 8'h1 >= nrx);
    unique case (mode)
      CSM_M_IDLE: begin
        next_midx = 4'h0;
        // Requests arriving while busy are not queued
        if (enable && cfg_valid_o && tx_start_i && ntx != 8'h0) begin
          next_frame = 64'h0;
          next_mode  = CSM_M_TX;
        end else if (enable && cfg_valid_o && rx_valid_i && nrx != 8'h0) begin
          next_rxbuf = rx_data_i;
          next_bad   = 1'b0;
          next_mode  = CSM_M_RXCHK;
        end
      end
      CSM_M_TX: begin
        next_frame = f_new;
        next_midx  = midx + 4'h1;
        if (last) begin
          next_tx_data  = f_new;
          next_tx_valid = 1'b1;
          next_mode     = CSM_M_IDLE;
        end
      end
      CSM_M_RXCHK: begin
        if (s_att[mslot][CSM_ATTR_INV] && inv != (~fld & m)) next_bad = 1'b1;
        next_midx = midx + 4'h1;
        if (last) begin
          next_midx = 4'h0;
          if (next_bad) begin
            ev_drop   = 1'b1;
            next_mode = CSM_M_IDLE;
            if (miss >= 2'(CSM_MISS_LIMIT - 1)) ev_plaus = 1'b1;
            else next_miss = miss + 2'h1;
          end else begin
            next_miss = 2'h0;
            ev_rx_ok  = 1'b1;
            next_mode = CSM_M_RXWR;
          end
        end
      end
      CSM_M_RXWR: begin
        next_snk_we    = 1'b1;
        next_snk_psel  = s_type[mslot] == CSM_TYPE_PARAM;
        next_snk_ssel  = s_type[mslot] == CSM_TYPE_SPEC;
        next_snk_index = s_idx[mslot];
        next_snk_value = fld[31:0];
        next_midx      = midx + 4'h1;
        if (last) next_mode = CSM_M_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      mode              <= CSM_M_IDLE;
      midx              <= 4'h0;
      frame             <= 64'h0;
      rxbuf             <= 64'h0;
      bad               <= 1'b0;
      miss              <= 2'h0;
      tx_data_o         <= 64'h0;
      tx_valid_o        <= 1'b0;
      snk_we_o          <= 1'b0;
      snk_param_sel_o   <= 1'b0;
      snk_special_sel_o <= 1'b0;
      snk_index_o       <= 16'h0;
      snk_value_o       <= 32'h0;
    end else begin
      mode              <= next_mode;
      midx              <= next_midx;
      frame             <= next_frame;
      rxbuf             <= next_rxbuf;
      bad               <= next_bad;
      miss              <= next_miss;
      tx_data_o         <= next_tx_data;
      tx_valid_o        <= next_tx_valid;
      snk_we_o          <= next_snk_we;
      snk_param_sel_o   <= next_snk_psel;
      snk_special_sel_o <= next_snk_ssel;
      snk_index_o       <= next_snk_index;
      snk_value_o       <= next_snk_value;
    end
  end

  // Receive message timeout, restarted by every accepted message
  always_comb begin
    next_tick_cnt = tick_cnt;
    next_ms_cnt   = ms_cnt;
    next_tmo_hit  = tmo_hit;
    ev_tmo        = 1'b0;
    if (!enable || !cfg_valid_o || tmo_ms == 16'h0 || ev_rx_ok) begin
      next_tick_cnt = '0;
      next_ms_cnt   = 16'h0;
      next_tmo_hit  = 1'b0;
    end else if (!tmo_hit) begin
      next_tick_cnt = tick_cnt + 1'b1;
      if (tick_cnt == $bits(tick_cnt)'(CYC_PER_MS - 1)) begin
        next_tick_cnt = '0;
        next_ms_cnt   = ms_cnt + 16'h1;
        if (ms_cnt + 16'h1 >= tmo_ms) begin
          ev_tmo       = 1'b1;
          next_tmo_hit = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      tick_cnt <= '0;
      ms_cnt   <= 16'h0;
      tmo_hit  <= 1'b0;
    end else begin
      tick_cnt <= next_tick_cnt;
      ms_cnt   <= next_ms_cnt;
      tmo_hit  <= next_tmo_hit;
    end
  end
endmodule

// ===== tb/csm_can_signal_mapper_properties.sv
// Purpose: Timing relations at the signal mapper's ports.
// Assumes: One clock domain, synchronous active-low reset.
// Notes:   Bound onto every instance of the mapper.
`timescale 1ns/1ps
module csm_props (
  input wire logic        ref_clk_i,
  input wire logic        reset_n_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic        avs_waitrequest_o,
  input wire logic        irq_o,
  input wire logic        tx_valid_o,
  input wire logic        snk_we_o,
  input wire logic        cfg_valid_o,
  input wire logic [15:0] bitrate_kbaud_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  a_wait_one: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("waitrequest held past one cycle");
  a_wait_idle: assert property (!avs_read_i && !avs_write_i |-> !avs_waitrequest_o)
    else $error("waitrequest without request");
  a_rst_quiet: assert property (disable iff (1'b0) !reset_n_i |=> !tx_valid_o && !snk_we_o && !irq_o && !cfg_valid_o)
    else $error("outputs active after reset");
  a_we_cfg: assert property (snk_we_o |-> cfg_valid_o)
    else $error("sink write without layout");
  a_tx_cfg: assert property (tx_valid_o |-> cfg_valid_o)
    else $error("send frame without layout");
  a_tx_pulse: assert property (tx_valid_o |=> !tx_valid_o)
    else $error("send valid longer than a pulse");
  a_cfg_hold: assert property (cfg_valid_o && !avs_write_i |=> cfg_valid_o)
    else $error("layout lost without write");
  a_rate_write: assert property ($changed(bitrate_kbaud_o) |-> $past(avs_write_i))
    else $error("bit rate changed without write");
  c_tx: cover property (tx_valid_o);
  c_we: cover property (snk_we_o);
  c_irq: cover property (irq_o);
endmodule
bind csm_can_signal_mapper csm_props u_props (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o),
  .tx_valid_o(tx_valid_o), .snk_we_o(snk_we_o), .cfg_valid_o(cfg_valid_o), .bitrate_kbaud_o(bitrate_kbaud_o));

// ===== tb/csm_vcu_model.sv
// Purpose: Vehicle controller side that hands received frames to the mapper.
// Assumes: Frames are whole 64-bit data fields.
// Notes:   Data is inverted every cycle outside the valid pulse, so a stale frame matches only on every second cycle.
`timescale 1ns/1ps
module csm_vcu_model (
  input  wire logic        clk_i,
  input  wire logic        go_i,
  input  wire logic [63:0] frame_i,
  output logic             rx_valid_o,
  output logic      [63:0] rx_data_o
);
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o  = 64'h0;
  end
  always @(posedge clk_i) begin
    rx_valid_o <= go_i;
    rx_data_o  <= go_i ? frame_i : ~rx_data_o;
  end
endmodule

// ===== tb/csm_can_signal_mapper_tb.sv
// Purpose: Self-checking bench for the signal mapper.
// Assumes: CYC_PER_MS shortened to 10 cycles.
// Notes:   One send and one receive layout loaded through the CFG register.
`timescale 1ns/1ps
module csm_can_signal_mapper_tb;
  import csm_pkg::*;
  logic clk = 0, rst_n = 0, rd = 0, wr = 0, tx_start = 0, go = 0, rx_v, wreq, irq, txv, we, ps, ss, pv, sv, cv, cfgv;
  logic [7:0] adr = 8'h0;
  logic [31:0] wd = 32'h0, rdat, q, val, sval;
  logic [15:0] sidx, idx, rate;
  logic [63:0] frame = 64'h0, rxd, txd;
  int fails = 0, total_checks = 0, wc, tc = 0;
  logic [17:0] wi;
  logic [7:0] cfg_b [26] = '{8'h02, 8'h02, 8'h00, 8'h03, 8'h00, 8'h10, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h05, 8'h00, 8'h04, 8'h10, 8'h04, 8'h01, 8'h00, 8'h00, 8'h07, 8'h00, 8'h08, 8'h00,
    8'h01, 8'hf4, 8'h01, 8'h00};
  typedef struct {logic [63:0] f; logic [31:0] e;} csm_row_s;
  csm_row_s rows [4] = '{'{64'ha55a, 32'h1005a}, '{64'h5a5a, 32'h0}, '{64'h3c3c, 32'h0}, '{64'hc33c, 32'h1003c}};
  // A wrong index yields zero, so a misrouted source shows up in the frame
  assign sval = (ss && sidx == 16'h0003) ? 32'h1234abcd : ((ps && sidx == 16'h0005) ? 32'h00000105 : 32'h0);
  csm_can_signal_mapper #(.CYC_PER_MS(10)) uut (.ref_clk_i(clk), .reset_n_i(rst_n), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hf), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .irq_o(irq), .tx_start_i(tx_start), .src_param_sel_o(ps), .src_special_sel_o(ss),
    .src_index_o(sidx), .src_value_i(sval), .tx_data_o(txd), .tx_valid_o(txv), .rx_valid_i(rx_v), .rx_data_i(rxd),
    .snk_we_o(we), .snk_param_sel_o(pv), .snk_special_sel_o(cv), .snk_index_o(idx), .snk_value_o(val),
    .bitrate_kbaud_o(rate), .cfg_valid_o(cfgv));
  csm_vcu_model u_vcu (.clk_i(clk), .go_i(go), .frame_i(frame), .rx_valid_o(rx_v), .rx_data_o(rxd));
  initial forever #10 clk = ~clk;
  always @(negedge clk) if (we === 1'b1) begin
    wc++;
    wi = {pv, cv, idx};
  end
  always @(negedge clk) if (txv === 1'b1) tc++;
  task chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    adr <= a;
    wd  <= d;
    wr  <= w;
    rd  <= !w;
    // Only the watchdog ends a wait that never sees the answer
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #400000;
    fails++;
    final_report;
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (cfg_b[i]) bus(1, CSM_REG_CFG, {24'h0, cfg_b[i]});
    bus(1, CSM_REG_CTRL, 32'h1);
    chk(rate, 16'h01f4);
    chk(cfgv, 1'b1);
    tx_start <= 1'b1;
    @(posedge clk);
    tx_start <= 1'b0;
    repeat (4) @(posedge clk);
    chk(txd, 64'h00000000000fabcd);
    chk(tc, 1);
    foreach (rows[i]) begin
      wc = 0; wi = '0;
      frame <= rows[i].f; go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (8) @(posedge clk);
      chk({8'(wc), val[15:0] & {16{rows[i].e[16]}}, wi}, {7'h0, rows[i].e[16:0], rows[i].e[16] ? {2'b10, 16'h0007} : 18'h0});
    end
    bus(0, CSM_REG_STATUS, 0);
    chk(q, 32'h16);
    bus(1, CSM_REG_STATUS, 32'h1f);
    bus(1, CSM_REG_MASK, 32'h1);
    bus(1, CSM_REG_TMO, 32'h1);
    repeat (30) @(posedge clk);
    chk({irq, q}, {1'b1, q});
    bus(0, CSM_REG_STATUS, 0);
    chk(q, 32'h1);
    bus(1, CSM_REG_MASK, 32'h0);
    chk(irq, 1'b0);
    bus(0, 8'h40, 0);
    chk(q, 32'h0);
    rst_n <= 1'b0;
    @(posedge clk);
    @(posedge clk);
    chk({rate, txv, we}, 18'h0);
    final_report;
  end
endmodule
